// ---- rtl/mgmt_device.sv ----
// management serial slave with indirect extended register access
`timescale 1ns/1ps
module mgmt_device (
  mgmt_if.dev link,
  input wire logic clk,
  input wire logic srst,
  input wire logic [mgmt_pkg::STRAP_W-1:0] phyStrap,
  output logic frameBusy
);
  typedef enum logic [2:0] {IDLE, START, HDR, TA1, RDATA, BODY} state_t;

  state_t state;
  logic [1:0] syncQ;
  logic mdcRise;
  logic bitIn;
  logic [mgmt_pkg::STRAP_W-1:0] myAddr;
  logic [11:0] hdr;
  logic [11:0] next_hdr;
  logic [17:0] body;
  logic [17:0] next_body;
  logic [4:0] cnt;
  logic [15:0] shift;
  logic [15:0] directReg [0:mgmt_pkg::DIRECT_WORDS-1];
  logic [15:0] extMem [0:mgmt_pkg::EXT_DEVS*mgmt_pkg::EXT_WORDS-1];
  logic [15:0] extPtr [0:mgmt_pkg::EXT_DEVS-1];
  logic [15:0] accessCtrl;
  logic [1:0] selIdx;
  logic [1:0] fn;
  logic [15:0] ptr;
  logic vendDirect;
  logic indDirectOk;
  logic indExtOk;
  logic [7:0] extIndex;
  logic [15:0] rdVal;
  logic hit;
  logic writeNow;
  logic [4:0] regAddr;

  // map a device-select value onto a storage slot
  function automatic logic [1:0] devIndex(input logic [4:0] sel);
    logic [1:0] idx;
    idx = mgmt_pkg::IDX_NONE;
    if (sel == mgmt_pkg::DEV_VENDOR) begin
      idx = mgmt_pkg::IDX_VENDOR;
    end else if (sel == mgmt_pkg::DEV_EEE_PCS) begin
      idx = mgmt_pkg::IDX_EEE_PCS;
    end else if (sel == mgmt_pkg::DEV_EEE_AN) begin
      idx = mgmt_pkg::IDX_EEE_AN;
    end
    return idx;
  endfunction

  // clock and data from the link pins, both synchronised
  sync_edge #(.W(2)) u_sync (
    .clk(clk),
    .srst(srst),
    .d({link.mdio, link.mdc}),
    .q(syncQ),
    .rise(mdcRise)
  );

  assign bitIn = syncQ[1];
  assign next_hdr = {hdr[10:0], bitIn};
  assign next_body = {body[16:0], bitIn};
  assign regAddr = hdr[mgmt_pkg::REG_W-1:0];
  assign hit = next_hdr[9:5] == {2'h0, myAddr};
  assign frameBusy = state != IDLE;

  // strap address caught while reset is held
  always_ff @(posedge clk) begin
    if (srst) begin
      myAddr <= phyStrap;
    end
  end

  // frame sequencer, moves only on management clock edges
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= IDLE;
      cnt <= 5'h00;
      hdr <= 12'h000;
      body <= 18'h00000;
    end else if (mdcRise) begin
      unique case (state)
        IDLE: begin
          if (!bitIn) begin
            state <= START;
          end
        end
        START: begin
          cnt <= 5'h00;
          state <= bitIn ? HDR : START;
        end
        HDR: begin
          hdr <= next_hdr;
          cnt <= cnt + 5'h01;
          if (cnt == mgmt_pkg::HDR_LAST) begin
            cnt <= 5'h00;
            if (next_hdr[11:10] == mgmt_pkg::OP_READ && hit) begin
              state <= TA1;
            end else begin
              state <= BODY;
            end
          end
        end
        TA1: begin
          cnt <= 5'h00;
          state <= RDATA;
        end
        RDATA: begin
          cnt <= cnt + 5'h01;
          if (cnt == mgmt_pkg::DATA_DONE) begin
            state <= IDLE;
          end
        end
        BODY: begin
          body <= next_body;
          cnt <= cnt + 5'h01;
          if (cnt == mgmt_pkg::BODY_LAST) begin
            state <= IDLE;
          end
        end
      endcase
    end
  end

  // pin driver: released, then zero, then sixteen data bits
  always_ff @(posedge clk) begin
    if (srst) begin
      link.mdioDevOe <= 1'b0;
      link.mdioDevOut <= 1'b0;
      shift <= 16'h0000;
    end else if (mdcRise) begin
      if (state == TA1) begin
        link.mdioDevOe <= 1'b1;
        link.mdioDevOut <= 1'b0;
        shift <= rdVal;
      end else if (state == RDATA) begin
        if (cnt == mgmt_pkg::DATA_DONE) begin
          link.mdioDevOe <= 1'b0;
          link.mdioDevOut <= 1'b0;
        end else begin
          link.mdioDevOut <= shift[15];
          shift <= {shift[14:0], 1'b0};
        end
      end else begin
        link.mdioDevOe <= 1'b0;
      end
    end
  end

  // indirect target decode
  always_comb begin
    selIdx = devIndex(accessCtrl[mgmt_pkg::DEVSEL_MSB:mgmt_pkg::DEVSEL_LSB]);
    fn = accessCtrl[mgmt_pkg::FN_MSB:mgmt_pkg::FN_LSB];
    ptr = (selIdx == mgmt_pkg::IDX_NONE) ? mgmt_pkg::WORD_RESET : extPtr[selIdx];
    vendDirect = selIdx == mgmt_pkg::IDX_VENDOR && ptr < mgmt_pkg::DIRECT_LIMIT;
    indDirectOk = vendDirect && ptr[4:0] != mgmt_pkg::REG_ACCESS_CTRL
      && ptr[4:0] != mgmt_pkg::REG_ADDR_DATA;
    indExtOk = !vendDirect && selIdx != mgmt_pkg::IDX_NONE && ptr < mgmt_pkg::EXT_LIMIT;
    extIndex = {selIdx, ptr[mgmt_pkg::EXT_AW-1:0]};
  end

  // read value for the addressed register
  always_comb begin
    rdVal = mgmt_pkg::WORD_RESET;
    if (regAddr == mgmt_pkg::REG_ACCESS_CTRL) begin
      rdVal = accessCtrl;
    end else if (regAddr == mgmt_pkg::REG_ADDR_DATA) begin
      if (selIdx != mgmt_pkg::IDX_NONE && fn == mgmt_pkg::FN_ADDRESS) begin
        rdVal = ptr;
      end else if (fn == mgmt_pkg::FN_DATA && indDirectOk) begin
        rdVal = directReg[ptr[4:0]];
      end else if (fn == mgmt_pkg::FN_DATA && indExtOk) begin
        rdVal = extMem[extIndex];
      end
    end else begin
      rdVal = directReg[regAddr];
    end
  end

  // write commits on the last data bit of a valid write frame
  assign writeNow = mdcRise && state == BODY && cnt == mgmt_pkg::BODY_LAST
    && hdr[11:10] == mgmt_pkg::OP_WRITE && hdr[9:5] == {2'h0, myAddr}
    && next_body[17:16] == mgmt_pkg::TA_WRITE;

  // register storage, pointers never move on data access
  always_ff @(posedge clk) begin
    if (srst) begin
      accessCtrl <= mgmt_pkg::WORD_RESET;
      for (int i = 0; i < mgmt_pkg::DIRECT_WORDS; i++) begin
        directReg[i] <= mgmt_pkg::WORD_RESET;
      end
      for (int i = 0; i < mgmt_pkg::EXT_DEVS; i++) begin
        extPtr[i] <= mgmt_pkg::WORD_RESET;
      end
      for (int i = 0; i < mgmt_pkg::EXT_DEVS * mgmt_pkg::EXT_WORDS; i++) begin
        extMem[i] <= mgmt_pkg::WORD_RESET;
      end
    end else if (writeNow) begin
      if (regAddr == mgmt_pkg::REG_ACCESS_CTRL) begin
        accessCtrl <= next_body[15:0];
      end else if (regAddr == mgmt_pkg::REG_ADDR_DATA) begin
        if (selIdx != mgmt_pkg::IDX_NONE && fn == mgmt_pkg::FN_ADDRESS) begin
          extPtr[selIdx] <= next_body[15:0];
        end else if (fn == mgmt_pkg::FN_DATA && indDirectOk) begin
          directReg[ptr[4:0]] <= next_body[15:0];
        end else if (fn == mgmt_pkg::FN_DATA && indExtOk) begin
          extMem[extIndex] <= next_body[15:0];
        end
      end else begin
        directReg[regAddr] <= next_body[15:0];
      end
    end
  end
endmodule

// ---- rtl/mgmt_host.sv ----
// station management controller with a wishbone register port
`timescale 1ns/1ps
module mgmt_host (
  mgmt_if.host link,
  input wire logic clk,
  input wire logic srst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck
);
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH} hstate_t;

  hstate_t state;
  logic mdioIn;
  logic busy;
  logic isRead;
  logic [4:0] cmdReg;
  logic [4:0] cmdPhy;
  logic cmdWrite;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] rdShift;
  logic [31:0] frame;
  logic [5:0] bitIdx;
  logic [5:0] next_bitIdx;
  logic [3:0] divCnt;
  logic wbReq;
  logic wbWr;
  logic start;

  // returned data line, from outside this clock domain
  sync_edge #(.W(1)) u_sync (
    .clk(clk),
    .srst(srst),
    .d(link.mdio),
    .q(mdioIn),
    .rise()
  );

  assign wbReq = wbCyc && wbStb && !wbAck;
  assign wbWr = wbReq && wbWe;
  assign start = wbWr && wbAdr == mgmt_pkg::WB_CMD && !busy && wbSel[0];
  assign next_bitIdx = bitIdx + 6'h01;

  // bus answer one cycle after the request
  always_ff @(posedge clk) begin
    if (srst) begin
      wbAck <= 1'b0;
      wbDatOut <= 32'h00000000;
    end else begin
      wbAck <= wbReq;
      wbDatOut <= 32'h00000000;
      if (wbReq && !wbWe) begin
        if (wbAdr == mgmt_pkg::WB_CMD) begin
          wbDatOut[mgmt_pkg::CMD_REG_LSB+:5] <= cmdReg;
          wbDatOut[mgmt_pkg::CMD_PHY_LSB+:5] <= cmdPhy;
          wbDatOut[mgmt_pkg::CMD_WRITE_BIT] <= cmdWrite;
        end else if (wbAdr == mgmt_pkg::WB_WDATA) begin
          wbDatOut[15:0] <= wdata;
        end else if (wbAdr == mgmt_pkg::WB_STATUS) begin
          wbDatOut[mgmt_pkg::STATUS_BUSY_BIT] <= busy;
        end else if (wbAdr == mgmt_pkg::WB_RDATA) begin
          wbDatOut[15:0] <= rdata;
        end
      end
    end
  end

  // command and write-data registers
  always_ff @(posedge clk) begin
    if (srst) begin
      cmdReg <= 5'h00;
      cmdPhy <= 5'h00;
      cmdWrite <= 1'b0;
      wdata <= 16'h0000;
    end else begin
      if (start) begin
        cmdReg <= wbDatIn[mgmt_pkg::CMD_REG_LSB+:5];
        cmdPhy <= wbDatIn[mgmt_pkg::CMD_PHY_LSB+:5];
        cmdWrite <= wbDatIn[mgmt_pkg::CMD_WRITE_BIT];
      end
      if (wbWr && wbAdr == mgmt_pkg::WB_WDATA) begin
        if (wbSel[0]) begin
          wdata[7:0] <= wbDatIn[7:0];
        end
        if (wbSel[1]) begin
          wdata[15:8] <= wbDatIn[15:8];
        end
      end
    end
  end

  // frame engine: bits change on the falling edge, sampled on rising
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= H_IDLE;
      busy <= 1'b0;
      isRead <= 1'b0;
      link.mdc <= 1'b0;
      link.mdioHostOe <= 1'b0;
      link.mdioHostOut <= 1'b1;
      frame <= 32'h00000000;
      bitIdx <= 6'h00;
      divCnt <= 4'h0;
      rdShift <= 16'h0000;
      rdata <= 16'h0000;
    end else begin
      unique case (state)
        H_IDLE: begin
          if (start) begin
            busy <= 1'b1;
            isRead <= !wbDatIn[mgmt_pkg::CMD_WRITE_BIT];
            frame <= {mgmt_pkg::START_CODE,
              wbDatIn[mgmt_pkg::CMD_WRITE_BIT] ? mgmt_pkg::OP_WRITE : mgmt_pkg::OP_READ,
              wbDatIn[mgmt_pkg::CMD_PHY_LSB+:5], wbDatIn[mgmt_pkg::CMD_REG_LSB+:5],
              wbDatIn[mgmt_pkg::CMD_WRITE_BIT] ? mgmt_pkg::TA_WRITE : mgmt_pkg::TA_RELEASED,
              wdata};
            bitIdx <= 6'h00;
            divCnt <= 4'h0;
            link.mdioHostOe <= 1'b1;
            link.mdioHostOut <= 1'b1;
            state <= H_LOW;
          end
        end
        H_LOW: begin
          divCnt <= divCnt + 4'h1;
          if (divCnt == mgmt_pkg::MDC_HALF_LAST) begin
            divCnt <= 4'h0;
            link.mdc <= 1'b1;
            state <= H_HIGH;
            if (isRead && bitIdx >= mgmt_pkg::RD_FIRST) begin
              rdShift <= {rdShift[14:0], mdioIn};
            end
          end
        end
        H_HIGH: begin
          divCnt <= divCnt + 4'h1;
          if (divCnt == mgmt_pkg::MDC_HALF_LAST) begin
            divCnt <= 4'h0;
            link.mdc <= 1'b0;
            if (bitIdx == mgmt_pkg::FRAME_LAST) begin
              state <= H_IDLE;
              busy <= 1'b0;
              link.mdioHostOe <= 1'b0;
              link.mdioHostOut <= 1'b1;
              if (isRead) begin
                rdata <= rdShift;
              end
            end else begin
              state <= H_LOW;
              bitIdx <= next_bitIdx;
              link.mdioHostOe <= !(isRead && next_bitIdx >= mgmt_pkg::RD_RELEASE);
              if (next_bitIdx >= mgmt_pkg::PREAMBLE_BITS) begin
                link.mdioHostOut <= frame[31];
                frame <= {frame[30:0], 1'b0};
              end
            end
          end
        end
      endcase
    end
  end
endmodule

// ---- rtl/sync_edge.sv ----
// two-flop synchroniser with rising-edge detect on bit 0
`timescale 1ns/1ps
module sync_edge #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic rise
);
  logic [W-1:0] meta;
  logic prev;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

  // edge detect on the settled copy
  always_ff @(posedge clk) begin
    if (srst) begin
      prev <= 1'b0;
    end else begin
      prev <= q[0];
    end
  end

  assign rise = q[0] & ~prev;
endmodule

// ---- shared/mgmt_if.sv ----
// management link between station controller and device
`timescale 1ns/1ps
interface mgmt_if;
  logic mdc;
  logic mdioHostOut;
  logic mdioHostOe;
  logic mdioDevOut;
  logic mdioDevOe;
  logic mdio;

  // wire level with pull-up when nobody drives
  assign mdio = mdioHostOe ? mdioHostOut : (mdioDevOe ? mdioDevOut : 1'b1);

  modport host (
    output mdc,
    output mdioHostOut,
    output mdioHostOe,
    input mdio
  );
  modport dev (
    input mdc,
    input mdio,
    output mdioDevOut,
    output mdioDevOe
  );
endinterface

// ---- shared/mgmt_pkg.sv ----
// constants shared by both ends of the management serial link
package mgmt_pkg;
  // clock rates and the management clock divider
  localparam int CLK_KHZ = 250000;
  localparam int MDC_MAX_KHZ = 24000;
  localparam int MDC_HALF = (CLK_KHZ + 2 * MDC_MAX_KHZ - 1) / (2 * MDC_MAX_KHZ);
  localparam logic [3:0] MDC_HALF_LAST = 4'(MDC_HALF - 1);
  // frame codes
  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [1:0] TA_RELEASED = 2'h3;
  // field widths
  localparam int PHY_W = 5;
  localparam int REG_W = 5;
  localparam int STRAP_W = 3;
  localparam int DATA_W = 16;
  // device bit counts, last index of header and body, release point after read data
  localparam logic [4:0] HDR_LAST = 5'h0B;
  localparam logic [4:0] BODY_LAST = 5'h11;
  localparam logic [4:0] DATA_DONE = 5'h10;
  // host bit positions within one 64-bit frame
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [5:0] RD_RELEASE = 6'h2E;
  localparam logic [5:0] RD_FIRST = 6'h30;
  localparam logic [5:0] FRAME_LAST = 6'h3F;
  // indirect access registers and device selects
  localparam logic [4:0] REG_ACCESS_CTRL = 5'h0D;
  localparam logic [4:0] REG_ADDR_DATA = 5'h0E;
  localparam logic [4:0] DEV_VENDOR = 5'h1F;
  localparam logic [4:0] DEV_EEE_PCS = 5'h03;
  localparam logic [4:0] DEV_EEE_AN = 5'h07;
  localparam int FN_MSB = 15;
  localparam int FN_LSB = 14;
  localparam int DEVSEL_MSB = 4;
  localparam int DEVSEL_LSB = 0;
  localparam logic [1:0] FN_ADDRESS = 2'h0;
  localparam logic [1:0] FN_DATA = 2'h1;
  localparam logic [1:0] IDX_VENDOR = 2'h0;
  localparam logic [1:0] IDX_EEE_PCS = 2'h1;
  localparam logic [1:0] IDX_EEE_AN = 2'h2;
  localparam logic [1:0] IDX_NONE = 2'h3;
  // storage sizes
  localparam int DIRECT_WORDS = 32;
  localparam int EXT_AW = 6;
  localparam int EXT_WORDS = 64;
  localparam int EXT_DEVS = 3;
  localparam logic [15:0] DIRECT_LIMIT = 16'h0020;
  localparam logic [15:0] EXT_LIMIT = 16'h0040;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // host register map on the wishbone side
  localparam logic [7:0] WB_CMD = 8'h00;
  localparam logic [7:0] WB_WDATA = 8'h04;
  localparam logic [7:0] WB_STATUS = 8'h08;
  localparam logic [7:0] WB_RDATA = 8'h0C;
  localparam int CMD_REG_LSB = 0;
  localparam int CMD_PHY_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int STATUS_BUSY_BIT = 0;
endpackage

// ---- verification/mgmt_link_asserts.sv ----
// concurrent checks on the management link wires
`timescale 1ns/1ps
module mgmt_link_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic mdc,
  input wire logic mdioHostOut,
  input wire logic mdioHostOe,
  input wire logic mdioDevOut,
  input wire logic mdioDevOe,
  input wire logic mdio
);
  logic mdcQ;
  logic oeQ;
  logic [5:0] bitCnt;
  logic [7:0] oeCnt;
  wire mdcRise = mdc && !mdcQ;

  // previous management clock and host enable
  always_ff @(posedge clk) begin
    mdcQ <= srst ? 1'b0 : mdc;
    oeQ <= srst ? 1'b0 : mdioHostOe;
  end
  // bit index within a frame, cleared when the host starts driving
  always_ff @(posedge clk) begin
    if (srst || (mdioHostOe && !oeQ)) bitCnt <= 6'h00;
    else if (mdcRise) bitCnt <= bitCnt + 6'h01;
  end
  // cycles the device has held the line
  always_ff @(posedge clk) begin
    if (srst || !mdioDevOe) oeCnt <= 8'h00;
    else oeCnt <= oeCnt + 8'h01;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_no_fight; !(mdioHostOe && mdioDevOe); endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive the line");
  property p_ta_zero; $rose(mdioDevOe) |-> !mdioDevOut; endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("device turnaround bit not zero");
  property p_dev_pos; $rose(mdioDevOe) |-> !mdioHostOe && bitCnt == 6'h2F; endproperty
  a_dev_pos: assert property (p_dev_pos) else $error("device drives at wrong bit");
  property p_mdc_high; $rose(mdc) |-> mdc [*6] ##1 !mdc; endproperty
  a_mdc_high: assert property (p_mdc_high) else $error("clock high phase wrong");
  property p_mdc_low; $fell(mdc) |-> !mdc [*6]; endproperty
  a_mdc_low: assert property (p_mdc_low) else $error("clock low phase short");
  property p_host_stable; mdc && mdioHostOe |-> $stable(mdioHostOut); endproperty
  a_host_stable: assert property (p_host_stable) else $error("host data moved while clock high");
  property p_dev_stands; mdioDevOe && $changed(mdioDevOut) |=> $stable(mdioDevOut) [*8]; endproperty
  a_dev_stands: assert property (p_dev_stands) else $error("device bit too short");
  property p_start; mdcRise && mdioHostOe && bitCnt == 6'h20 |-> !mdio ##12 mdio; endproperty
  a_start: assert property (p_start) else $error("start pattern wrong");
  property p_rd_ta; mdcRise && !mdioHostOe && bitCnt == 6'h2E |-> mdio && !mdioDevOe; endproperty
  a_rd_ta: assert property (p_rd_ta) else $error("first read turnaround driven");
  property p_wr_ta; mdcRise && mdioHostOe && bitCnt == 6'h2E |-> mdio ##12 !mdio; endproperty
  a_wr_ta: assert property (p_wr_ta) else $error("write turnaround wrong");
  property p_dev_span; $fell(mdioDevOe) |-> oeCnt inside {[200:208]}; endproperty
  a_dev_span: assert property (p_dev_span) else $error("device drive length wrong");
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for the host and device pair
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin failures++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'hF;
  logic [31:0] wbDatIn = 32'h00000000;
  logic [31:0] wbDatOut;
  logic wbAck;
  logic frameBusy;
  logic [2:0] strap = 3'h0;
  logic [4:0] me = 5'h00;
  logic [15:0] lfsr = 16'h425D;
  logic [15:0] dreg [32];
  logic [15:0] ext [3][64];
  logic [15:0] ptr [3];
  logic [4:0] dv [4] = '{5'h1F, 5'h03, 5'h07, 5'h05};
  int failures = 0;
  int n_compared = 0;

  mgmt_if lk();
  mgmt_host mgmt_host_i(.link(lk), .clk(clk), .srst(srst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck));
  mgmt_device mgmt_device_i(.link(lk), .clk(clk), .srst(srst), .phyStrap(strap), .frameBusy(frameBusy));
  mgmt_link_asserts mgmt_link_asserts_i(.clk(clk), .srst(srst), .mdc(lk.mdc), .mdioHostOut(lk.mdioHostOut),
    .mdioHostOe(lk.mdioHostOe), .mdioDevOut(lk.mdioDevOut), .mdioDevOe(lk.mdioDevOe), .mdio(lk.mdio));

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  // verdict and end of run
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog well past the expected run length
  initial begin
    #400000;
    failures++;
    summarize();
  end

  // pseudo-random source, one lfsr step per call
  function automatic void rnd(output logic [15:0] v);
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    v = lfsr;
  endfunction

  // one classic wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatIn <= dat;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    rd = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask

  // one management frame through the host registers
  task automatic op(input logic [4:0] phy, input logic [4:0] ra, input logic w, input logic [15:0] d,
    output logic [15:0] q);
    logic [31:0] r;
    int n;
    n = 0;
    wb(1'b1, mgmt_pkg::WB_WDATA, {16'h0000, d}, r);
    wb(1'b1, mgmt_pkg::WB_CMD, {15'h0000, w, 3'h0, phy, 3'h0, ra}, r);
    do begin
      wb(1'b0, mgmt_pkg::WB_STATUS, 32'h00000000, r);
      n++;
    end while (r[0] !== 1'b0 && n < 2000);
    if (n >= 2000) failures++;
    wb(1'b0, mgmt_pkg::WB_RDATA, 32'h00000000, r);
    q = r[15:0];
  endtask

  // reference model of one register access at the device
  task automatic mref(input logic [4:0] ra, input logic w, input logic [15:0] d, output logic [15:0] q);
    int i;
    int p;
    logic [1:0] fn;
    i = -1;
    fn = dreg[13][15:14];
    if (dreg[13][4:0] == 5'h1F) i = 0;
    if (dreg[13][4:0] == 5'h03) i = 1;
    if (dreg[13][4:0] == 5'h07) i = 2;
    q = 16'h0000;
    p = (i >= 0) ? int'(ptr[i]) : 0;
    if (ra != 5'h0E) begin
      q = dreg[ra];
      if (w) dreg[ra] = d;
    end else if (i >= 0 && fn == 2'h0) begin
      q = ptr[i];
      if (w) ptr[i] = d;
    end else if (i == 0 && fn == 2'h1 && p < 32 && p != 13 && p != 14) begin
      q = dreg[p];
      if (w) dreg[p] = d;
    end else if (i >= 0 && fn == 2'h1 && (i > 0 || p >= 32) && p < 64) begin
      q = ext[i][p];
      if (w) ext[i][p] = d;
    end
  endtask

  // frame plus model; reads compared, other stations read as pulled-up line
  task automatic acc(input logic [4:0] phy, input logic [4:0] ra, input logic w, input logic [15:0] d);
    logic [15:0] q;
    logic [15:0] e;
    op(phy, ra, w, d, q);
    e = 16'hFFFF;
    if (phy === me) mref(ra, w, d, e);
    if (!w) `CHK("read data", e, q)
  endtask

  // pointer load, pointer readback, mode switch, data write and two reads
  task automatic ind(input logic [4:0] dsel, input logic [15:0] p, input logic [1:0] fn, input logic [15:0] d);
    acc(me, 5'h0D, 1'b1, {2'h0, 9'h000, dsel});
    acc(me, 5'h0E, 1'b1, p);
    acc(me, 5'h0E, 1'b0, 16'h0000);
    acc(me, 5'h0D, 1'b1, {fn, 9'h000, dsel});
    acc(me, 5'h0E, 1'b1, d);
    acc(me, 5'h0E, 1'b0, 16'h0000);
    acc(me, 5'h0E, 1'b0, 16'h0000);
  endtask

  // main sequence
  initial begin
    logic [15:0] v;
    logic [31:0] r;
    logic [4:0] ra;
    for (int i = 0; i < 32; i++) dreg[i] = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      ptr[i] = 16'h0000;
      for (int j = 0; j < 64; j++) ext[i][j] = 16'h0000;
    end
    rnd(v);
    strap <= v[2:0];
    me = {2'b00, v[2:0]};
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // direct registers, random place and data, back to back
    for (int k = 0; k < 6; k++) begin
      rnd(v);
      ra = v[4:0];
      rnd(v);
      acc(me, ra, 1'b1, v);
      acc(me, ra, 1'b0, 16'h0000);
    end
    acc(me, 5'h1F, 1'b1, 16'hA5C3);
    acc(me, 5'h1F, 1'b0, 16'h0000);
    $display("test direct done");
    // frames for other stations are ignored
    acc(me ^ 5'h01, 5'h03, 1'b1, 16'h1234);
    acc(me ^ 5'h10, 5'h03, 1'b0, 16'h0000);
    acc(me, 5'h03, 1'b0, 16'h0000);
    $display("test station address done");
    // every device select plus an unsupported one
    foreach (dv[i]) begin
      rnd(v);
      ind(dv[i], {10'h000, v[5:0]}, 2'h1, v ^ 16'h5A5A);
    end
    ind(5'h1F, 16'h000D, 2'h1, 16'hBEEF);
    ind(5'h1F, 16'h0005, 2'h1, 16'h0F0F);
    acc(me, 5'h05, 1'b0, 16'h0000);
    ind(5'h1F, 16'h0022, 2'h2, 16'h7777);
    acc(me, 5'h0D, 1'b0, 16'h0000);
    $display("test indirect done");
    // unmapped host address answers zero
    wb(1'b1, 8'h10, 32'hFFFFFFFF, r);
    wb(1'b0, 8'h10, 32'h00000000, r);
    `CHK("unmapped", 32'h00000000, r)
    `CHK("idle line", 1'b1, lk.mdio)
    `CHK("busy", 1'b0, frameBusy)
    // host command and write-data registers read back
    wb(1'b0, mgmt_pkg::WB_CMD, 32'h00000000, r);
    `CHK("command", {15'h0000, 1'b0, 3'h0, me, 3'h0, 5'h0D}, r)
    wb(1'b1, mgmt_pkg::WB_WDATA, 32'hFFFFC3A5, r);
    wb(1'b0, mgmt_pkg::WB_WDATA, 32'h00000000, r);
    `CHK("write data", 32'h0000C3A5, r)
    $display("test idle done");
    summarize();
  end
endmodule
